// ==== rtl/gpio_consts.svh ====
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define AXI_ADDR_W 8
`define PORT_A_LATCH_OFS 8'h00
`define PORT_A_DIR_OFS 8'h04
`define PORT_A_PULLUP_OFS 8'h08
`define ANALOG_DIS_LO_OFS 8'h0c
`define PORT_B_LATCH_OFS 8'h10
`define PORT_B_DIR_OFS 8'h14
`define PORT_B_PULLUP_OFS 8'h18
`define ANALOG_DIS_HI_OFS 8'h1c
`define STANDBY_CMP_CTRL_OFS 8'h20

// ----------------------------------------------------------------------
// Widths, field positions and reset values
// ----------------------------------------------------------------------
`define PORT_A_W 8
`define PORT_B_W 4
`define PIN_COUNT 12
`define CMP0_NEG_PIN 0
`define CMP0_POS_PIN 1
`define CMP1_NEG_PIN 3
`define CMP1_POS_PIN 4
`define CTRL_W 5
`define LATCH_RESET 8'h00
`define DIR_RESET 8'h00
`define PULLUP_RESET 8'h00
`define ANALOG_DIS_RESET 8'h00
`define CTRL_RESET 5'h0a
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== rtl/gpio_pkg.sv ====
`include "gpio_consts.svh"

package gpio_pkg;

   // Peripheral claim of the pins: output enable and value per pin
   typedef struct packed {
      logic [`PIN_COUNT-1:0] oe;
      logic [`PIN_COUNT-1:0] val;
   } periph_drive_t;

   // Standby pin-state select and comparator input controls
   typedef struct packed {
      logic cmp1_neg_sel;
      logic cmp1_in_en_n;
      logic cmp0_neg_sel;
      logic cmp0_in_en_n;
      logic pin_state_sel;
   } standby_cmp_ctrl_t;

   // Comparator input switch enables, per channel
   typedef struct packed {
      logic [1:0] pos;
      logic [1:0] neg;
   } cmp_enable_t;

endpackage

// ==== rtl/gpio_port.sv ====
`include "gpio_consts.svh"

// Operation
// R1: Direction one means output, zero input
// R2: Output pin drives its latch bit
// R3: Writes always load latch, input pins undriven
// R4: Output-mode data read returns latch
// R5: Input read gives pin, RMW read latch
// R6: Peripheral drives claimed pin, read shows pin
// R7: Peripheral input pin reads pin, RMW latch
// R8: Analog-disable one enables digital input path
// R9: Reset clears direction and analog-disable bits
// R10: Standby with select one floats, blocks inputs
// R11: Standby with select zero keeps pin states
// R12: Pull-up on when enabled, off driving low
// R13: Software prepares analog pins before use
// R14: Software disables peripheral outputs for port use
// R15: Positive comparator input follows enable bit only
// R16: Negative comparator input needs both bits zero
// R17: Eight-pin port bit n controls pin n
// R18: Four-pin port implements bits zero to three
// R19: RMW qualifier selects latch on data reads
module gpio_port (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic [`AXI_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // Write data channel
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response channel
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read address channel, with read-modify-write qualifier
   input wire logic [`AXI_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic read_is_rmw,
   output logic arready,
   // Read data channel
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Pads, port B in the upper four bits
   input wire logic [`PIN_COUNT-1:0] pad_in,
   output logic [`PIN_COUNT-1:0] pad_out,
   output logic [`PIN_COUNT-1:0] pad_oe_n,
   output logic [`PIN_COUNT-1:0] pullup_en,
   // Shared peripherals and analog blocks
   input gpio_pkg::periph_drive_t periph_drive,
   output logic [`PIN_COUNT-1:0] periph_in,
   output logic [`PIN_COUNT-1:0] analog_sel,
   output gpio_pkg::cmp_enable_t cmp_enable,
   // Stop or watch mode from the standby controller
   input wire logic standby_active
);

   // ---------------------------------------------------------------
   // Register file state
   // ---------------------------------------------------------------
   logic [`PORT_A_W-1:0] port_a_output_latch_q; // Data latch, port A
   logic [`PORT_A_W-1:0] port_a_direction_q; // One per pin, 1 = output
   logic [`PORT_A_W-1:0] port_a_pullup_enable_q; // Pull-up request
   logic [`PORT_A_W-1:0] analog_disable_low_half_q; // 1 = digital input
   logic [`PORT_B_W-1:0] port_b_output_latch_q; // Data latch, port B
   logic [`PORT_B_W-1:0] port_b_direction_q; // Direction, port B
   logic [`PORT_B_W-1:0] port_b_pullup_enable_q; // Pull-up, port B
   logic [`PORT_B_W-1:0] analog_disable_high_half_q; // Digital enable, B
   gpio_pkg::standby_cmp_ctrl_t ctrl_q; // Standby and comparator bits

   // Both ports joined, pin n of port A at bit n
   logic [`PIN_COUNT-1:0] latch_all;
   logic [`PIN_COUNT-1:0] dir_all;
   logic [`PIN_COUNT-1:0] pul_all;
   logic [`PIN_COUNT-1:0] aid_all;

   // ---------------------------------------------------------------
   // Bus handshake state
   // ---------------------------------------------------------------
   logic aw_full_q; // Write address held
   logic w_full_q; // Write data held
   logic [`AXI_ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic ar_full_q; // Read address held
   logic [`AXI_ADDR_W-1:0] ar_addr_q;
   logic ar_rmw_q; // Read belongs to a read-modify-write
   logic aw_take, w_take, ar_take, wr_commit, rd_commit;
   logic aw_full_d, w_full_d, ar_full_d;

   // ---------------------------------------------------------------
   // Pin path signals
   // ---------------------------------------------------------------
   logic [`PIN_COUNT-1:0] sync1_q, sync2_q, sync3_q; // Pad synchroniser
   logic [`PIN_COUNT-1:0] pin_level_q; // Settled pad level
   logic standby_hiz; // Pins forced to float
   logic [`PIN_COUNT-1:0] drive_en; // Pin driven by port or peripheral
   logic [`PIN_COUNT-1:0] drive_val; // Value that would be driven
   logic [`PIN_COUNT-1:0] din_gated; // Digital input after blocking
   logic [`PIN_COUNT-1:0] rd_sel_latch; // Data read takes latch bit
   logic [`PIN_COUNT-1:0] port_rd; // Data read value of all pins
   logic [31:0] rd_word; // Decoded read word
   logic rd_hit, wr_hit; // Address is mapped

   // Bit n of each register is pin n, port B above port A
   assign latch_all = {port_b_output_latch_q, port_a_output_latch_q}; // R17 R18
   assign dir_all = {port_b_direction_q, port_a_direction_q}; // R17 R18
   assign pul_all = {port_b_pullup_enable_q, port_a_pullup_enable_q};
   assign aid_all = {analog_disable_high_half_q, analog_disable_low_half_q};

   // ---------------------------------------------------------------
   // AXI4-Lite handshakes
   // ---------------------------------------------------------------
   // Accept conditions and commit points
   always_comb begin
      aw_take = awvalid & awready;
      w_take = wvalid & wready;
      ar_take = arvalid & arready;
      wr_commit = aw_full_q & w_full_q & ~bvalid;
      rd_commit = ar_full_q & ~rvalid;
      aw_full_d = (aw_full_q & ~wr_commit) | aw_take;
      w_full_d = (w_full_q & ~wr_commit) | w_take;
      ar_full_d = (ar_full_q & ~rd_commit) | ar_take;
   end

   // Write address and data capture, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         awready <= ~aw_full_d;
         wready <= ~w_full_d;
         // Payloads held until the commit
         if (aw_take) begin
            aw_addr_q <= awaddr;
         end
         if (w_take) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
      end
   end

   // Write response, held until bready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else if (wr_commit) begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read address capture with its qualifier
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_full_q <= 1'b0;
         arready <= 1'b0;
         ar_addr_q <= '0;
         ar_rmw_q <= 1'b0;
      end else begin
         ar_full_q <= ar_full_d;
         arready <= ~ar_full_d & ~rvalid;
         if (ar_take) begin
            ar_addr_q <= araddr;
            ar_rmw_q <= read_is_rmw; // R19
         end
      end
   end

   // Read data, held until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= `RESP_OKAY;
      end else if (rd_commit) begin
         rvalid <= 1'b1;
         rdata <= rd_word;
         rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   // Only byte lane 0 carries register bits
   always_comb begin
      case (aw_addr_q)
         `PORT_A_LATCH_OFS, `PORT_A_DIR_OFS, `PORT_A_PULLUP_OFS,
         `ANALOG_DIS_LO_OFS, `PORT_B_LATCH_OFS, `PORT_B_DIR_OFS,
         `PORT_B_PULLUP_OFS, `ANALOG_DIS_HI_OFS,
         `STANDBY_CMP_CTRL_OFS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Latch loads whatever the direction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_a_output_latch_q <= `LATCH_RESET;
         port_a_direction_q <= `DIR_RESET; // R9
         port_a_pullup_enable_q <= `PULLUP_RESET;
         analog_disable_low_half_q <= `ANALOG_DIS_RESET; // R9
         port_b_output_latch_q <= 4'(`LATCH_RESET);
         port_b_direction_q <= 4'(`DIR_RESET); // R9
         port_b_pullup_enable_q <= 4'(`PULLUP_RESET);
         analog_disable_high_half_q <= 4'(`ANALOG_DIS_RESET); // R9
         ctrl_q <= `CTRL_RESET;
      end else if (wr_commit && w_strb_q[0]) begin
         case (aw_addr_q)
            `PORT_A_LATCH_OFS: port_a_output_latch_q <= w_data_q[7:0]; // R3
            `PORT_A_DIR_OFS: port_a_direction_q <= w_data_q[7:0];
            `PORT_A_PULLUP_OFS: port_a_pullup_enable_q <= w_data_q[7:0];
            `ANALOG_DIS_LO_OFS: analog_disable_low_half_q <= w_data_q[7:0];
            `PORT_B_LATCH_OFS: port_b_output_latch_q <= w_data_q[3:0]; // R3
            `PORT_B_DIR_OFS: port_b_direction_q <= w_data_q[3:0];
            `PORT_B_PULLUP_OFS: port_b_pullup_enable_q <= w_data_q[3:0];
            `ANALOG_DIS_HI_OFS: analog_disable_high_half_q <= w_data_q[3:0];
            `STANDBY_CMP_CTRL_OFS: ctrl_q <= w_data_q[4:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   // Data reads pick latch or settled pin level per bit
   always_comb begin
      rd_sel_latch = {`PIN_COUNT{ar_rmw_q}} | (dir_all & ~periph_drive.oe); // R4 R5 R19
      port_rd = (rd_sel_latch & latch_all) | (~rd_sel_latch & din_gated); // R6 R7
   end

   // Address decode; bits above each register read zero
   always_comb begin
      rd_hit = 1'b1;
      rd_word = '0;
      case (ar_addr_q)
         `PORT_A_LATCH_OFS: rd_word[7:0] = port_rd[7:0];
         `PORT_A_DIR_OFS: rd_word[7:0] = port_a_direction_q;
         `PORT_A_PULLUP_OFS: rd_word[7:0] = port_a_pullup_enable_q;
         `ANALOG_DIS_LO_OFS: rd_word[7:0] = analog_disable_low_half_q;
         `PORT_B_LATCH_OFS: rd_word[3:0] = port_rd[11:8];
         `PORT_B_DIR_OFS: rd_word[3:0] = port_b_direction_q;
         `PORT_B_PULLUP_OFS: rd_word[3:0] = port_b_pullup_enable_q;
         `ANALOG_DIS_HI_OFS: rd_word[3:0] = analog_disable_high_half_q;
         `STANDBY_CMP_CTRL_OFS: rd_word[4:0] = ctrl_q;
         default: rd_hit = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Pad input synchroniser
   // ---------------------------------------------------------------
   // Level moves only when stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
         pin_level_q <= '0;
      end else begin
         sync1_q <= pad_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         pin_level_q <= (sync2_q & sync3_q) | (pin_level_q & (sync2_q ^ sync3_q));
      end
   end

   // ---------------------------------------------------------------
   // Pin function selection
   // ---------------------------------------------------------------
   // Peripheral claim wins over the port latch
   always_comb begin
      standby_hiz = ctrl_q.pin_state_sel & standby_active; // R10 R11
      drive_en = periph_drive.oe | dir_all; // R1 R6
      drive_val = (periph_drive.oe & periph_drive.val) |
                  (~periph_drive.oe & latch_all); // R2
      din_gated = pin_level_q & aid_all & {`PIN_COUNT{~standby_hiz}}; // R8 R10
   end

   // Pad drivers and pull-ups; drivers floated in blocking standby, pull-ups kept as enabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_oe_n <= '1;
         pad_out <= '0;
         pullup_en <= '0;
      end else begin
         pad_oe_n <= standby_hiz ? '1 : ~drive_en; // R1 R10 R11
         pad_out <= drive_val; // R2
         pullup_en <= pul_all & ~(drive_en & ~drive_val & {`PIN_COUNT{~standby_hiz}}); // R12
      end
   end

   // Digital and analog paths toward the peripherals
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periph_in <= '0;
         analog_sel <= '1;
      end else begin
         periph_in <= din_gated; // R8 R10
         analog_sel <= ~aid_all; // R8
      end
   end

   // Comparator input switches, independent of data and direction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_enable <= '0;
      end else begin
         cmp_enable.pos[0] <= ~ctrl_q.cmp0_in_en_n; // R15
         cmp_enable.pos[1] <= ~ctrl_q.cmp1_in_en_n; // R15
         cmp_enable.neg[0] <= ~ctrl_q.cmp0_in_en_n & ~ctrl_q.cmp0_neg_sel; // R16
         cmp_enable.neg[1] <= ~ctrl_q.cmp1_in_en_n & ~ctrl_q.cmp1_neg_sel; // R16
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Direction and claim decide the pad enable
   dir_drive_en_a: assert property (!standby_hiz |=> // R1
      pad_oe_n == ~($past(dir_all) | $past(periph_drive.oe)))
      else $error("pad enable does not follow direction");

   // Unclaimed output pins show the latch
   latch_drive_a: assert property (!standby_hiz |=> // R2
      ((pad_out ^ $past(latch_all)) & ~$past(periph_drive.oe)) == '0)
      else $error("pad value differs from latch");

   // Written byte lands in the latch
   latch_write_a: assert property ((wr_commit && w_strb_q[0] && // R3
      aw_addr_q == `PORT_A_LATCH_OFS) |=> port_a_output_latch_q == $past(w_data_q[7:0]))
      else $error("latch write lost");

   // Ordinary read of output pins returns latch
   out_read_a: assert property ((rd_commit && !ar_rmw_q && // R4
      ar_addr_q == `PORT_A_LATCH_OFS) |=>
      ((rdata[7:0] ^ $past(latch_all[7:0])) & $past(dir_all[7:0]) & ~$past(periph_drive.oe[7:0])) == '0)
      else $error("output pin read not latch");

   // Read-modify-write read returns latch in full
   rmw_read_a: assert property ((rd_commit && ar_rmw_q && // R5
      ar_addr_q == `PORT_B_LATCH_OFS) |=> rdata == {28'h0000000, $past(latch_all[11:8])})
      else $error("rmw read not latch");

   // Digital input gated by analog-disable, analog select its inverse
   digital_gate_a: assert property (1'b1 |=> // R8
      (periph_in & ~$past(aid_all)) == '0 && analog_sel == ~$past(aid_all))
      else $error("digital path open on analog pin");

   // Reset leaves all pins input and analog
   reset_dir_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> // R9
      dir_all == '0 && aid_all == '0)
      else $error("direction or analog-disable not cleared");

   // Blocking standby floats and grounds inputs
   standby_float_a: assert property (standby_hiz |=> // R10
      pad_oe_n == '1 && periph_in == '0)
      else $error("pins not floated in standby");

   // Non-blocking standby keeps pin drive
   standby_keep_a: assert property ((standby_active && !ctrl_q.pin_state_sel) |=> // R11
      pad_oe_n == ~($past(dir_all) | $past(periph_drive.oe)))
      else $error("standby changed pin state");

   // No pull-up on a pin driven low
   pullup_low_a: assert property ( // R12
      (pullup_en & ~pad_oe_n & ~pad_out) == '0)
      else $error("pull-up on while driving low");

   // Comparator switches pos[1] and neg[0] follow their control bits
   cmp_enable_a: assert property (1'b1 |=> // R15 R16
      cmp_enable.pos[1] == !$past(ctrl_q.cmp1_in_en_n) &&
      cmp_enable.neg[0] == ($past(ctrl_q.cmp0_in_en_n) == 1'b0 && !$past(ctrl_q.cmp0_neg_sel)))
      else $error("comparator enable wrong");

endmodule // gpio_port

// ==== testbench/gpio_pin_model.sv ====
`include "gpio_consts.svh"

// --------------------
// Pin-side model
// --------------------
module gpio_pin_model (
   // Clock for the floating pattern
   input wire logic aclk,
   // Pads from the port
   input wire logic [`PIN_COUNT-1:0] pad_out,
   input wire logic [`PIN_COUNT-1:0] pad_oe_n,
   input wire logic [`PIN_COUNT-1:0] pullup_en,
   // Outside circuit on the pins
   input wire logic ext_en,
   input wire logic [`PIN_COUNT-1:0] ext_lvl,
   // Resolved pin levels
   output logic [`PIN_COUNT-1:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [`PIN_COUNT-1:0] float_q = 12'h0; // Level of a released pin

   // Released pins without pull-up wander every cycle
   always_ff @(posedge aclk) begin
      float_q <= ~float_q;
   end

   // Port drive wins, then the outside circuit, then the pull-up
   always_comb begin
      for (int i = 0; i < `PIN_COUNT; i++) begin
         if (!pad_oe_n[i]) begin
            pad_in[i] = pad_out[i];
         end else if (ext_en) begin
            pad_in[i] = ext_lvl[i];
         end else if (pullup_en[i]) begin
            pad_in[i] = 1'h1;
         end else begin
            pad_in[i] = float_q[i];
         end
      end
   end
endmodule // gpio_pin_model

// ==== testbench/gpio_port_with_analog_disable_tb_top.sv ====
`include "gpio_consts.svh"

module gpio_port_with_analog_disable_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // --------------------
   // Signals
   // --------------------
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
   logic rready = 1'h0, read_is_rmw = 1'h0, standby_active = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic [11:0] pad_in, pad_out, pad_oe_n, pullup_en, periph_in, analog_sel;
   logic [11:0] ext_lvl = 12'h0; // Level forced from outside
   logic [11:0] lat, dir, pu, ad, ext, drv, val, pin, poe, pval;
   logic [4:0] ctl;
   logic sb, blk;
   gpio_pkg::periph_drive_t periph_drive = 24'h0;
   gpio_pkg::cmp_enable_t cmp_enable;
   int seed = 90, miscompares = 0, cmp_count = 0, cyc = 0;

   always #20 aclk = ~aclk;

   gpio_port u_gpio_port (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .read_is_rmw(read_is_rmw),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pullup_en(pullup_en), .periph_drive(periph_drive), .periph_in(periph_in),
      .analog_sel(analog_sel), .cmp_enable(cmp_enable),
      .standby_active(standby_active));

   gpio_pin_model u_gpio_pin_model (.aclk(aclk), .pad_out(pad_out),
      .pad_oe_n(pad_oe_n), .pullup_en(pullup_en), .ext_en(1'h1),
      .ext_lvl(ext_lvl), .pad_in(pad_in));

   // --------------------
   // Tasks
   // --------------------
   // Verdict and end of run
   task automatic wrap_up();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Compare and count
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   // Bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'h0;
   endtask

   // Bus read, with the read-modify-write qualifier
   task automatic rd(input logic [7:0] a, input logic m, output logic [31:0] v,
                     output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a;
      read_is_rmw <= m;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
      end while (!rvalid);
      v = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask

   // Register view of one port
   function automatic logic [7:0] pk(input int p, input logic [11:0] x);
      return p ? {4'h0, x[11:8]} : x[7:0];
   endfunction

   // Expected data-register read of all pins
   function automatic logic [11:0] rd_exp(input logic m);
      logic [11:0] s;
      s = {12{m}} | (dir & ~poe);
      return (s & lat) | (~s & pin & ad & {12{~blk}});
   endfunction

   // Hang guard
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         wrap_up();
      end
   end

   // --------------------
   // Main sequence
   // --------------------
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      chk("pad_oe_n", 32'hfff, 32'(pad_oe_n));
      chk("analog_sel", 32'hfff, 32'(analog_sel));
      for (int a = 0; a < 9; a++) begin
         rd(8'(a * 4), 1'h0, d, r);
         chk("reset value", (a == 8) ? 32'h0a : 32'h0, d);
      end
      // Unmapped place
      wr(8'h24, 32'hff, r);
      chk("bresp", 32'h2, 32'(r));
      rd(8'h24, 1'h0, d, r);
      chk("rdata", 32'h0, d);
      chk("rresp", 32'h2, 32'(r));
      // Random setups with all-zero and all-one corners first
      for (int it = 0; it < 40; it++) begin
         lat = 12'($random(seed));
         dir = 12'($random(seed));
         pu = 12'($random(seed));
         ad = 12'($random(seed));
         ext = 12'($random(seed));
         poe = 12'($random(seed));
         pval = 12'($random(seed));
         ctl = 5'($random(seed));
         sb = 1'($random(seed));
         if (it < 2) {lat, dir, pu, ad, poe} = {5{{12{it[0]}}}};
         // Analog use prepared by software, then plain port use
         if (it == 2) {dir, pu, ad, poe} = 48'h0;
         if (it == 3) poe = 12'h0;
         for (int p = 0; p < 2; p++) begin
            wr(8'(p * 16), {24'h0, pk(p, lat)}, r);
            wr(8'(p * 16 + 4), {24'h0, pk(p, dir)}, r);
            wr(8'(p * 16 + 8), {24'h0, pk(p, pu)}, r);
            wr(8'(p * 16 + 12), {24'h0, pk(p, ad)}, r);
         end
         wr(8'h20, {27'h0, ctl}, r);
         chk("bresp", 32'h0, 32'(r));
         periph_drive <= {poe, pval};
         ext_lvl <= ext;
         standby_active <= sb;
         repeat (8) @(posedge aclk);
         blk = ctl[0] & sb;
         drv = (dir | poe) & {12{~blk}};
         val = (poe & pval) | (~poe & lat);
         pin = (drv & val) | (~drv & ext);
         chk("pad_oe_n", {20'h0, ~drv}, 32'(pad_oe_n));
         chk("pad_out", {20'h0, val & drv}, {20'h0, pad_out & drv});
         chk("pullup_en", {20'h0, pu & ~(drv & ~val)}, 32'(pullup_en));
         chk("analog_sel", {20'h0, ~ad}, 32'(analog_sel));
         chk("periph_in", {20'h0, pin & ad & {12{~blk}}}, 32'(periph_in));
         chk("cmp_enable", {28'h0, ~ctl[3], ~ctl[1], ~(ctl[3] | ctl[4]),
             ~(ctl[1] | ctl[2])}, 32'(cmp_enable));
         rd(8'h20, 1'h0, d, r);
         chk("control", {27'h0, ctl}, d);
         chk("rresp", 32'h0, 32'(r));
         for (int p = 0; p < 2; p++) begin
            rd(8'(p * 16), 1'h0, d, r);
            chk("data read", {24'h0, pk(p, rd_exp(1'h0))}, d);
            rd(8'(p * 16), 1'h1, d, r);
            chk("rmw read", {24'h0, pk(p, lat)}, d);
            rd(8'(p * 16 + 4), 1'h0, d, r);
            chk("direction", {24'h0, pk(p, dir)}, d);
            rd(8'(p * 16 + 8), 1'h0, d, r);
            chk("pullup", {24'h0, pk(p, pu)}, d);
            rd(8'(p * 16 + 12), 1'h0, d, r);
            chk("analog_dis", {24'h0, pk(p, ad)}, d);
         end
      end
      wrap_up();
   end
endmodule // gpio_port_with_analog_disable_tb_top
